// File: rtl/radio_cfg_pkg.sv
package radio_cfg_pkg;
  typedef logic [7:0] cnt_t;
  localparam int MCLK_NS = 20;
  localparam int SCLK_HALF_NS = 160;
  localparam int SEL_SETUP_NS = 1000;
  localparam int SEL_GAP_NS = 90;
  localparam cnt_t SCLK_HALF_CYC = cnt_t'((SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS);
  localparam cnt_t SEL_SETUP_CYC = cnt_t'((SEL_SETUP_NS + MCLK_NS - 1) / MCLK_NS);
  localparam cnt_t SEL_GAP_CYC = cnt_t'((SEL_GAP_NS + MCLK_NS - 1) / MCLK_NS);
  localparam logic FLAG_WRITE = 1'b0;
  localparam logic FLAG_READ = 1'b1;
  localparam logic [1:0] ADDR_FIRST = 2'h0;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] HDR_LAST_BIT = 3'h2;
  localparam logic [2:0] DATA_LAST_BIT = 3'h7;
  localparam logic [4:0] HDR_BITS = 5'h03;
  localparam int SLEEP_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RXEXT_B0 = 8'h00;
  localparam logic [7:0] RXEXT_B1 = 8'h00;
  localparam logic [7:0] RXINT_B0 = 8'h01;
  localparam logic [7:0] RXINT_B1 = 8'h04;
  localparam logic [7:0] TX_B0 = 8'h40;
  localparam logic [7:0] TX_B1 = 8'h20;
  localparam logic [7:0] SLEEP_B0 = 8'h80;
  localparam logic [7:0] SLEEP_B1 = 8'h00;
  localparam logic [1:0] MODE_NBYTES = 2'h2;

  typedef enum logic [1:0] {
    MODE_RX_EXT = 2'h0,
    MODE_RX_INT = 2'h1,
    MODE_TX = 2'h2,
    MODE_SLEEP = 2'h3
  } mode_cmd_t;

  function automatic logic [1:0] next_addr(input logic [1:0] a);
    next_addr = (a >= ADDR_LAST) ? ADDR_FIRST : a + 2'h1;
  endfunction

  function automatic logic [4:0] frame_last_bit(input logic rd, input logic [1:0] n);
    logic [1:0] nb;
    nb = (rd || n == 2'h0) ? 2'h1 : n;
    frame_last_bit = HDR_BITS + {nb, 3'h0} - 5'h01;
  endfunction
endpackage

// File: rtl/cfg_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cfg_link_if;
  logic select;
  logic sclk;
  logic host_data_out;
  logic host_data_oe;
  logic dev_data_out;
  logic dev_data_oe;
  logic data;
  // Undriven line floats high through a pull-up
  assign data = host_data_oe ? host_data_out : (dev_data_oe ? dev_data_out : 1'b1);
  modport device_mp (input select, input sclk, input data, output dev_data_out,
                     output dev_data_oe);
  modport host_mp (output select, output sclk, output host_data_out, output host_data_oe,
                   input data);
endinterface
`default_nettype wire

// File: rtl/radio_config_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
module radio_config_serial_port
  import radio_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  cfg_link_if.device_mp link,
  output logic [7:0] config_byte_zero,
  output logic [7:0] config_byte_one,
  output logic [7:0] config_byte_two,
  output logic serial_control_mode,
  output logic sleep_mode
);
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_HDR = 2'b01,
    D_WDATA = 2'b11,
    D_RDATA = 2'b10
  } dev_state_t;

  dev_state_t state;
  logic [1:0] sel_sync, clk_sync, dat_sync;
  logic sel_q, clk_q;
  logic [2:0] bit_cnt;
  logic [1:0] addr;
  logic [7:0] shreg;
  logic [7:0] cfg_mem [0:2];
  logic dev_out, dev_oe, mode_serial, sleeping;

  wire sel = sel_sync[1];
  wire dat = dat_sync[1];
  wire sel_rise = sel & ~sel_q;
  wire sel_fall = ~sel & sel_q;
  wire clk_rise = sel & clk_sync[1] & ~clk_q;
  wire [7:0] shifted = {shreg[6:0], dat};
  wire [1:0] hdr_addr = {shreg[0], dat};
  wire hdr_read = shreg[1] == FLAG_READ;
  // Address 3 holds nothing and reads as zero
  wire [7:0] hdr_rd_val = (hdr_addr <= ADDR_LAST) ? cfg_mem[hdr_addr] : 8'h00;
  wire byte_done = clk_rise && state == D_WDATA && bit_cnt == DATA_LAST_BIT;

  assign config_byte_zero = cfg_mem[0];
  assign config_byte_one = cfg_mem[1];
  assign config_byte_two = cfg_mem[2];
  assign serial_control_mode = mode_serial;
  assign sleep_mode = sleeping;
  assign link.dev_data_out = dev_out;
  assign link.dev_data_oe = dev_oe;

  // Two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_sync <= 2'h0;
      clk_sync <= 2'h0;
      dat_sync <= 2'h0;
      sel_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      sel_sync <= {sel_sync[0], link.select};
      clk_sync <= {clk_sync[0], link.sclk};
      dat_sync <= {dat_sync[0], link.data};
      sel_q <= sel_sync[1];
      clk_q <= clk_sync[1];
    end
  end

  // Mode starts legacy after reset, so a low strap needs no capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_serial <= 1'b0;
    end else if (sel) begin
      mode_serial <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_mem[0] <= CFG_RESET;
      cfg_mem[1] <= CFG_RESET;
      cfg_mem[2] <= CFG_RESET;
      sleeping <= 1'b0;
    end else if (sel_rise) begin
      sleeping <= 1'b0;
    end else if (byte_done && addr <= ADDR_LAST) begin
      cfg_mem[addr] <= shifted;
      if (addr == ADDR_FIRST) begin
        sleeping <= shifted[SLEEP_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= D_IDLE;
      bit_cnt <= 3'h0;
      addr <= ADDR_FIRST;
      shreg <= 8'h00;
      dev_out <= 1'b0;
      dev_oe <= 1'b0;
    end else if (sel_fall || !sel) begin
      state <= D_IDLE;
      dev_oe <= 1'b0;
    end else if (sel_rise) begin
      state <= D_HDR;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
    end else if (clk_rise) begin
      case (state)
        D_HDR: begin
          shreg <= shifted;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == HDR_LAST_BIT) begin
            addr <= hdr_addr;
            bit_cnt <= 3'h0;
            if (hdr_read) begin
              state <= D_RDATA;
              shreg <= hdr_rd_val;
            end else begin
              state <= D_WDATA;
            end
          end
        end
        D_WDATA: begin
          shreg <= shifted;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == DATA_LAST_BIT) begin
            addr <= next_addr(addr);
            bit_cnt <= 3'h0;
          end
        end
        D_RDATA: begin
          dev_out <= shreg[7];
          dev_oe <= 1'b1;
          shreg <= {shreg[6:0], 1'b0};
        end
        default: begin
          state <= D_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: rtl/radio_config_host.sv
`timescale 1ns/1ns
`default_nettype none
module radio_config_host
  import radio_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  cfg_link_if.host_mp link,
  input wire logic start,
  input wire logic read,
  input wire logic [1:0] addr,
  input wire logic [1:0] nbytes,
  input wire logic [23:0] wdata,
  input wire logic mode_start,
  input wire mode_cmd_t mode_cmd,
  output logic busy,
  output logic done,
  output logic [7:0] rdata
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SETUP = 3'b001,
    H_HIGH = 3'b011,
    H_LOW = 3'b010,
    H_TAIL = 3'b110,
    H_GAP = 3'b111
  } host_state_t;

  function automatic logic [15:0] mode_bytes(input mode_cmd_t m);
    case (m)
      MODE_RX_EXT: mode_bytes = {RXEXT_B0, RXEXT_B1};
      MODE_RX_INT: mode_bytes = {RXINT_B0, RXINT_B1};
      MODE_TX: mode_bytes = {TX_B0, TX_B1};
      MODE_SLEEP: mode_bytes = {SLEEP_B0, SLEEP_B1};
      default: mode_bytes = {RXEXT_B0, RXEXT_B1};
    endcase
  endfunction

  host_state_t state;
  cnt_t cnt;
  logic [4:0] bit_idx, last_idx;
  logic [26:0] shreg;
  logic [1:0] dat_sync;
  logic rd, sel, sclk, hout, hoe;

  // Mode commands take priority and always write from address 0
  wire [26:0] user_word = {read, addr, wdata[7:0], wdata[15:8], wdata[23:16]};
  wire [26:0] mode_word = {FLAG_WRITE, ADDR_FIRST, mode_bytes(mode_cmd), 8'h00};
  wire [26:0] load_word = mode_start ? mode_word : user_word;
  wire load_rd = mode_start ? FLAG_WRITE : read;
  wire [1:0] load_n = mode_start ? MODE_NBYTES : nbytes;
  wire half_end = cnt == SCLK_HALF_CYC - cnt_t'(1);
  wire rd_phase = rd && bit_idx >= HDR_BITS;

  assign link.select = sel;
  assign link.sclk = sclk;
  assign link.host_data_out = hout;
  assign link.host_data_oe = hoe;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dat_sync <= 2'h0;
    end else begin
      dat_sync <= {dat_sync[0], link.data};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= H_IDLE;
      cnt <= 8'h00;
      bit_idx <= 5'h00;
      last_idx <= 5'h00;
      shreg <= 27'h0;
      rd <= 1'b0;
      sel <= 1'b0;
      sclk <= 1'b0;
      hout <= 1'b0;
      hoe <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      cnt <= cnt + 8'h01;
      case (state)
        H_IDLE: begin
          cnt <= 8'h00;
          if (start || mode_start) begin
            state <= H_SETUP;
            shreg <= load_word;
            rd <= load_rd;
            last_idx <= frame_last_bit(load_rd, load_n);
            bit_idx <= 5'h00;
            sel <= 1'b1;
            hout <= load_word[26];
            hoe <= 1'b1;
            busy <= 1'b1;
          end
        end
        H_SETUP: begin
          // Long setup covers wake from sleep as well
          if (cnt == SEL_SETUP_CYC - cnt_t'(1)) begin
            state <= H_HIGH;
            sclk <= 1'b1;
            cnt <= 8'h00;
          end
        end
        H_HIGH: begin
          if (half_end) begin
            sclk <= 1'b0;
            cnt <= 8'h00;
            if (rd_phase) begin
              rdata <= {rdata[6:0], dat_sync[1]};
            end
            if (rd && bit_idx == 5'(HDR_LAST_BIT)) begin
              hoe <= 1'b0;
            end
            shreg <= {shreg[25:0], 1'b0};
            hout <= shreg[25];
            if (bit_idx == last_idx) begin
              state <= H_TAIL;
            end else begin
              state <= H_LOW;
              bit_idx <= bit_idx + 5'h01;
            end
          end
        end
        H_LOW: begin
          if (half_end) begin
            sclk <= 1'b1;
            state <= H_HIGH;
            cnt <= 8'h00;
          end
        end
        H_TAIL: begin
          if (half_end) begin
            sel <= 1'b0;
            hoe <= 1'b0;
            state <= H_GAP;
            cnt <= 8'h00;
          end
        end
        H_GAP: begin
          // Device release time is covered before the line is driven again
          if (cnt == SEL_GAP_CYC - cnt_t'(1)) begin
            state <= H_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: dv/radio_config_serial_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module radio_config_serial_port_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic select,
  input wire logic sclk,
  input wire logic host_data_out,
  input wire logic host_data_oe,
  input wire logic dev_data_out,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_one_driver;
    !(host_data_oe && dev_data_oe);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("data driven by both ends");
  property p_release;
    $fell(select) |-> ##[0:4] !dev_data_oe;
  endproperty
  a_release: assert property (p_release) else $error("data not released");
  property p_sclk_idle;
    !select |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock outside frame");
  property p_quiet_start;
    $rose(select) |-> (!sclk) [*8];
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("clock too soon");
  property p_dev_in_read;
    $rose(dev_data_oe) |-> select && !host_data_oe;
  endproperty
  a_dev_in_read: assert property (p_dev_in_read) else $error("device drives early");
  property p_wr_setup;
    $rose(sclk) && host_data_oe |-> $stable(host_data_out);
  endproperty
  a_wr_setup: assert property (p_wr_setup) else $error("data moved at rise");
  property p_wr_hold;
    $rose(sclk) && host_data_oe |=> $stable(host_data_out) [*4];
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("data hold short");
  property p_rd_valid;
    $fell(sclk) && dev_data_oe |-> dev_data_out == $past(dev_data_out, 3);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read bit unstable");
  property p_frame_end;
    $rose(select) |-> ##[200:600] !select;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame length off");
endmodule
`default_nettype wire

// File: dv/radio_config_serial_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module radio_config_serial_port_tb_top;
  import radio_cfg_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic read = 1'b0;
  logic mode_start = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [1:0] nbytes = 2'h0;
  logic [23:0] wdata = 24'h000000;
  mode_cmd_t mode_cmd = MODE_RX_EXT;
  logic done;
  logic busy;
  logic scm;
  logic slp;
  logic scm2;
  logic [7:0] rdata, b0, b1, b2, c0, c1;
  int num_errors = 0;
  int checks_done = 0;
  cfg_link_if l1();
  cfg_link_if l2();
  always #10 mclk = ~mclk;
  radio_config_host u_radio_config_host (.mclk(mclk), .rst_n(rst_n), .link(l1),
    .start(start), .read(read), .addr(addr), .nbytes(nbytes), .wdata(wdata),
    .mode_start(mode_start), .mode_cmd(mode_cmd), .busy(busy), .done(done), .rdata(rdata));
  radio_config_serial_port u_radio_config_serial_port (.mclk(mclk), .rst_n(rst_n),
    .link(l1), .config_byte_zero(b0), .config_byte_one(b1), .config_byte_two(b2),
    .serial_control_mode(scm), .sleep_mode(slp));
  // Second device is driven bit by bit to break the framing on purpose, then with one full write frame
  radio_config_serial_port u_radio_config_serial_port_b (.mclk(mclk), .rst_n(rst_n),
    .link(l2), .config_byte_zero(c0), .config_byte_one(c1), .config_byte_two(),
    .serial_control_mode(scm2), .sleep_mode());
  radio_config_serial_port_checker u_radio_config_serial_port_checker (.mclk(mclk),
    .rst_n(rst_n), .select(l1.select), .sclk(l1.sclk), .host_data_out(l1.host_data_out),
    .host_data_oe(l1.host_data_oe), .dev_data_out(l1.dev_data_out),
    .dev_data_oe(l1.dev_data_oe));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic test_done;
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic host_op(input logic rd, input logic [1:0] a, input logic [1:0] nb,
                         input logic [23:0] wd, input logic ms, input logic [1:0] mc);
    int k;
    read = rd;
    addr = a;
    nbytes = nb;
    wdata = wd;
    mode_cmd = mode_cmd_t'(mc);
    start = !ms;
    mode_start = ms;
    tick(1);
    start = 1'b0;
    mode_start = 1'b0;
    chk("busy", 8'h01, {7'h00, busy});
    k = 0;
    while (done !== 1'b1 && k < 2000) begin
      tick(1);
      k++;
    end
    if (done !== 1'b1) begin
      chk("done", 8'h01, {7'h00, done});
      test_done();
    end
    chk("busy", 8'h00, {7'h00, busy});
  endtask

  // Bit-bang on the spare link, 4 cycles each half period
  task automatic bang(input logic [10:0] bits, input int n, input logic sel);
    l2.select = sel;
    l2.host_data_oe = 1'b1;
    tick(50);
    for (int i = n - 1; i >= 0; i--) begin
      l2.host_data_out = bits[i];
      tick(4);
      l2.sclk = 1'b1;
      tick(4);
      l2.sclk = 1'b0;
    end
    tick(8);
    l2.select = 1'b0;
    l2.host_data_oe = 1'b0;
    tick(8);
  endtask

  task automatic t_reset;
    chk("mode", 8'h00, scm);
    chk("byte0", 8'h00, b0);
    chk("byte2", 8'h00, b2);
  endtask

  task automatic t_wrap;
    host_op(1'b0, 2'h1, 2'h3, 24'h3c96a5, 1'b0, 2'h0);
    chk("byte1", 8'ha5, b1);
    chk("byte2", 8'h96, b2);
    chk("byte0", 8'h3c, b0);
    chk("mode", 8'h01, scm);
  endtask

  task automatic t_read;
    logic [7:0] exp [4] = '{8'h3c, 8'ha5, 8'h96, 8'h00};
    for (int i = 0; i < 4; i++) begin
      host_op(1'b1, 2'(i), 2'h0, 24'h000000, 1'b0, 2'h0);
      chk("rdata", exp[i], rdata);
    end
  endtask

  task automatic t_modes;
    logic [7:0] m0 [4] = '{8'h00, 8'h01, 8'h40, 8'h80};
    logic [7:0] m1 [4] = '{8'h00, 8'h04, 8'h20, 8'h00};
    for (int m = 0; m < 4; m++) begin
      host_op(1'b0, 2'h0, 2'h0, 24'h000000, 1'b1, 2'(m));
      chk("byte0", m0[m], b0);
      chk("byte1", m1[m], b1);
      chk("byte2", 8'h96, b2);
      chk("sleep", {7'h00, m == 3}, slp);
    end
    host_op(1'b1, 2'h2, 2'h0, 24'h000000, 1'b0, 2'h0);
    chk("sleep", 8'h00, slp);
    chk("rdata", 8'h96, rdata);
  endtask

  task automatic t_spare;
    chk("mode2", 8'h00, scm2);
    bang(11'h0ff, 11, 1'b0);
    chk("c0", 8'h00, c0);
    chk("mode2", 8'h00, scm2);
    bang(11'h01f, 8, 1'b1);
    chk("c0", 8'h00, c0);
    chk("mode2", 8'h01, scm2);
    bang(11'h055, 11, 1'b1);
    chk("c0", 8'h55, c0);
    chk("c1", 8'h00, c1);
  endtask

  initial begin
    l2.select = 1'b0;
    l2.sclk = 1'b0;
    l2.host_data_out = 1'b0;
    l2.host_data_oe = 1'b0;
    repeat (16) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    tick(4);
    t_reset();
    t_wrap();
    t_read();
    t_modes();
    t_spare();
    test_done();
  end
endmodule
`default_nettype wire
